// *** hw/iads_line_if.sv ***
`timescale 1ns/1ps
interface iads_line_if;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic sdaLvl;
  modport mon  (output sclRise, output sclFall, output startDet, output stopDet, output sdaLvl);
  modport core (input sclRise, input sclFall, input startDet, input stopDet, input sdaLvl);
endinterface

// *** hw/iads_line_mon.sv ***
`timescale 1ns/1ps
module iads_line_mon (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       sclPin,
  input  wire logic       sdaPin,
  iads_line_if.mon        line
);
  // ----------------------------------------------------------------
  // two-stage synchronisers plus one history stage
  // ----------------------------------------------------------------
  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  logic [2:0] next_sclSync;
  logic [2:0] next_sdaSync;

  always_comb begin
    next_sclSync = {sclSync[1:0], sclPin};
    next_sdaSync = {sdaSync[1:0], sdaPin};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
    end else begin
      sclSync <= next_sclSync;
      sdaSync <= next_sdaSync;
    end
  end

  // stage 0 is read only by stage 1
  assign line.sclRise  = sclSync[1] & ~sclSync[2];
  assign line.sclFall  = ~sclSync[1] & sclSync[2];
  assign line.startDet = sclSync[1] & sclSync[2] & ~sdaSync[1] & sdaSync[2];
  assign line.stopDet  = sclSync[1] & sclSync[2] & sdaSync[1] & ~sdaSync[2];
  assign line.sdaLvl   = sdaSync[1];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_start_excl_stop;
    !(line.startDet && line.stopDet);
  endproperty
  a_start_excl_stop: assert property (p_start_excl_stop)
    else $error("start and stop flagged together");

endmodule // iads_line_mon

// *** hw/iads_pkg.sv ***
package iads_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int         APB_AW        = 8;
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_LADDR     = 8'h08;
  localparam logic [7:0] OFF_SHIFT     = 8'h0c;
  localparam logic [7:0] OFF_INT_STAT  = 8'h10;
  localparam logic [7:0] OFF_INT_CLR   = 8'h14;
  localparam logic [7:0] OFF_INT_EN    = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_EXIT_BIT  = 6;
  localparam int CTRL_WREL_BIT  = 5;
  localparam int CTRL_STG_BIT   = 1;
  localparam int STAT_MSTR_BIT  = 7;
  localparam int STAT_ARB_BIT   = 6;
  localparam int STAT_MATCH_BIT = 4;
  localparam int STAT_DIR_BIT   = 3;
  localparam int INT_W          = 4;
  localparam int INT_MATCH_BIT  = 0;
  localparam int INT_ARB_BIT    = 1;
  localparam int INT_START_BIT  = 2;
  localparam int INT_STOP_BIT   = 3;

  // ----------------------------------------------------------------
  // reset values and bit counts
  // ----------------------------------------------------------------
  localparam logic [7:0]       LADDR_RST  = 8'h00;
  localparam logic [7:0]       SHIFT_RST  = 8'hff;
  localparam logic [INT_W-1:0] INT_EN_RST = 4'h0;
  localparam logic [3:0]       CNT_EIGHTH = 4'h8;
  localparam logic [3:0]       CNT_NINTH  = 4'h9;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11
  } iads_phase_t;

endpackage

// *** hw/iads_status_top.sv ***
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module iads_status_top
  import iads_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [iads_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         sclIn,
  input  wire logic                         sdaIn,
  output logic                              sdaOut,
  output logic                              sdaOeN,
  output logic                              irq
);
  import iads_pkg::*;

  iads_line_if line ();

  iads_line_mon uLineMon (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sclPin  (sclIn),
    .sdaPin  (sdaIn),
    .line    (line)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              unitEn,       next_unitEn;
  logic [7:0]        localAddr,    next_localAddr;
  logic [7:0]        txShift,      next_txShift;
  logic [7:0]        rxShift,      next_rxShift;
  logic              masterStatus, next_masterStatus;
  logic              arbLost,      next_arbLost;
  logic              addrMatch,    next_addrMatch;
  logic              txDir,        next_txDir;
  logic              txValid,      next_txValid;
  logic              ackSlot,      next_ackSlot;
  logic [3:0]        bitCnt,       next_bitCnt;
  iads_phase_t       phase,        next_phase;
  logic [INT_W-1:0]  intStat,      next_intStat;
  logic [INT_W-1:0]  intEn,        next_intEn;
  logic              next_sdaOut;
  logic              next_sdaOeN;
  logic              next_irq;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic             acc, wr, rd, setup, mapped;
  logic             wrCtrl, exitPulse, wrelPulse, stgPulse, disEdge, rdStatus;
  logic             startD, stopD, byteDone, driving, lostNow, setMatch, dirClr;
  logic [7:0]       rxByte;
  logic [INT_W-1:0] events;
  logic [31:0]      rdMux;

  always_comb begin
    setup     = psel && !penable;
    acc       = psel && penable && pready;
    wr        = acc && pwrite;
    rd        = acc && !pwrite;
    mapped    = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_LADDR) ||
                (paddr == OFF_SHIFT) || (paddr == OFF_INT_STAT) ||
                (paddr == OFF_INT_CLR) || (paddr == OFF_INT_EN);
    wrCtrl    = wr && (paddr == OFF_CTRL);
    exitPulse = wrCtrl && pwdata[CTRL_EXIT_BIT] && unitEn;
    wrelPulse = wrCtrl && pwdata[CTRL_WREL_BIT] && unitEn;
    stgPulse  = wrCtrl && pwdata[CTRL_STG_BIT] && unitEn;
    disEdge   = wrCtrl && !pwdata[CTRL_EN_BIT] && unitEn;
    rdStatus  = rd && (paddr == OFF_STATUS);
    rdMux     = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL:     rdMux[CTRL_EN_BIT] = unitEn;
      OFF_STATUS: begin
        rdMux[STAT_MSTR_BIT]  = masterStatus;
        rdMux[STAT_ARB_BIT]   = arbLost;
        rdMux[STAT_MATCH_BIT] = addrMatch;
        rdMux[STAT_DIR_BIT]   = txDir;
      end
      OFF_LADDR:    rdMux[7:0] = localAddr;
      OFF_SHIFT:    rdMux[7:0] = txShift;
      OFF_INT_STAT: rdMux[INT_W-1:0] = intStat;
      OFF_INT_EN:   rdMux[INT_W-1:0] = intEn;
      default:      rdMux = 32'h0000_0000;
    endcase
    next_pready  = setup;
    next_pslverr = setup && !mapped;
    next_prdata  = (setup && !pwrite) ? rdMux : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------
  always_comb begin
    startD   = line.startDet && unitEn;
    stopD    = line.stopDet && unitEn;
    rxByte   = {rxShift[6:0], line.sdaLvl};
    byteDone = unitEn && line.sclRise && (phase == PH_ADDR) && (bitCnt == CNT_EIGHTH - 4'h1);
    driving  = !sdaOeN;
    lostNow  = unitEn && line.sclRise && masterStatus && driving && sdaOut && !line.sdaLvl;
    setMatch = byteDone && !masterStatus && (rxByte[7:1] == localAddr[7:1]);
    dirClr   = stopD || exitPulse || disEdge || wrelPulse || (lostNow && !arbLost) ||
               (startD && !masterStatus);
    events                = '0;
    events[INT_MATCH_BIT] = setMatch;
    events[INT_ARB_BIT]   = lostNow;
    events[INT_START_BIT] = startD;
    events[INT_STOP_BIT]  = stopD;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_unitEn       = unitEn;
    next_localAddr    = localAddr;
    next_txShift      = txShift;
    next_rxShift      = rxShift;
    next_masterStatus = masterStatus;
    next_arbLost      = arbLost;
    next_addrMatch    = addrMatch;
    next_txDir        = txDir;
    next_txValid      = txValid;
    next_ackSlot      = ackSlot;
    next_bitCnt       = bitCnt;
    next_phase        = phase;
    next_intEn        = intEn;

    if (wrCtrl) begin
      next_unitEn = pwdata[CTRL_EN_BIT];
    end
    if (wr && (paddr == OFF_LADDR)) begin
      next_localAddr = pwdata[7:0];
    end
    if (wr && (paddr == OFF_INT_EN)) begin
      next_intEn = pwdata[INT_W-1:0];
    end

    // byte framing on the synchronised clock line
    if (startD) begin
      next_phase   = PH_ADDR;
      next_bitCnt  = 4'h0;
      next_txValid = 1'b0;
      next_ackSlot = 1'b0;
    end else if (stopD || exitPulse || disEdge) begin
      next_phase   = PH_IDLE;
      next_bitCnt  = 4'h0;
      next_txValid = 1'b0;
      next_ackSlot = 1'b0;
    end else if (phase != PH_IDLE) begin
      if (line.sclRise && (bitCnt < CNT_NINTH)) begin
        next_bitCnt = bitCnt + 4'h1;
        if (bitCnt < CNT_EIGHTH) begin
          next_rxShift = rxByte;
        end
      end
      if (line.sclFall) begin
        if (bitCnt == CNT_NINTH) begin
          next_bitCnt  = 4'h0;
          next_ackSlot = 1'b0;
          next_phase   = PH_DATA;
          next_txValid = 1'b1;
        end else if (bitCnt == CNT_EIGHTH) begin
          next_ackSlot = 1'b1;
        end else if ((bitCnt != 4'h0) && driving) begin
          // only a driving transmitter walks its latch; a listener keeps it
          next_txShift = {txShift[6:0], 1'b1};
        end
      end
    end
    if (wr && (paddr == OFF_SHIFT)) begin
      next_txShift = pwdata[7:0];
    end

    // master status and arbitration
    if (stgPulse) begin
      next_masterStatus = 1'b1;
    end
    if (stopD || exitPulse || disEdge) begin
      next_masterStatus = 1'b0;
    end
    if (rdStatus || disEdge) begin
      next_arbLost = 1'b0;
    end
    if (lostNow) begin
      next_arbLost      = 1'b1;
      next_masterStatus = 1'b0;
    end

    // address match, hardware only
    if (startD || stopD || exitPulse || disEdge) begin
      next_addrMatch = 1'b0;
    end
    if (setMatch) begin
      next_addrMatch = 1'b1;
    end

    // transfer direction, hardware only
    if (dirClr) begin
      next_txDir = 1'b0;
    end
    if (stgPulse && !lostNow) begin
      next_txDir = 1'b1;
    end
    if (byteDone) begin
      if (masterStatus) begin
        next_txDir = !txShift[7];
      end else begin
        next_txDir = line.sdaLvl;
      end
    end

    // data line drive, released during the ninth bit
    if (next_txDir && (next_masterStatus || next_txValid) && !next_ackSlot) begin
      next_sdaOeN = 1'b0;
      next_sdaOut = next_txShift[7];
    end else begin
      next_sdaOeN = 1'b1;
      next_sdaOut = 1'b1;
    end

    // sticky events, a new event wins over a clear
    next_intStat = intStat;
    if (wr && (paddr == OFF_INT_CLR)) begin
      next_intStat = intStat & ~pwdata[INT_W-1:0];
    end
    next_intStat = next_intStat | events;
    next_irq     = |(next_intStat & next_intEn);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unitEn       <= 1'b0;
      localAddr    <= LADDR_RST;
      txShift      <= SHIFT_RST;
      rxShift      <= 8'h00;
      masterStatus <= 1'b0;
      arbLost      <= 1'b0;
      addrMatch    <= 1'b0;
      txDir        <= 1'b0;
      txValid      <= 1'b0;
      ackSlot      <= 1'b0;
      bitCnt       <= 4'h0;
      phase        <= PH_IDLE;
      intStat      <= '0;
      intEn        <= INT_EN_RST;
      sdaOut       <= 1'b1;
      sdaOeN       <= 1'b1;
      irq          <= 1'b0;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end else begin
      unitEn       <= next_unitEn;
      localAddr    <= next_localAddr;
      txShift      <= next_txShift;
      rxShift      <= next_rxShift;
      masterStatus <= next_masterStatus;
      arbLost      <= next_arbLost;
      addrMatch    <= next_addrMatch;
      txDir        <= next_txDir;
      txValid      <= next_txValid;
      ackSlot      <= next_ackSlot;
      bitCnt       <= next_bitCnt;
      phase        <= next_phase;
      intStat      <= next_intStat;
      intEn        <= next_intEn;
      sdaOut       <= next_sdaOut;
      sdaOeN       <= next_sdaOeN;
      irq          <= next_irq;
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_match_seen;
    setMatch;
  endsequence
  sequence s_wrel_req;
    wrelPulse && txDir && !byteDone && !stgPulse;
  endsequence

  property p_match_set;
    s_match_seen |=> addrMatch ##0 intStat[INT_MATCH_BIT];
  endproperty
  a_match_set: assert property (p_match_set)
    else $error("address match flag not set");

  property p_match_clr;
    (startD || stopD || exitPulse || disEdge) && !setMatch |=> !addrMatch;
  endproperty
  a_match_clr: assert property (p_match_clr)
    else $error("address match flag not cleared");

  property p_rx_release;
    !txDir |-> sdaOeN;
  endproperty
  a_rx_release: assert property (p_rx_release)
    else $error("line driven in receive status");

  property p_tx_drive;
    !sdaOeN |-> txDir && (sdaOut == txShift[7]);
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("line driven from wrong source");

  property p_dir_clr;
    (stopD || exitPulse || disEdge) && !byteDone && !stgPulse |=> !txDir ##1
      (!txDir || $past(stgPulse) || $past(byteDone));
  endproperty
  a_dir_clr: assert property (p_dir_clr)
    else $error("direction flag not cleared");

  property p_master_dir;
    byteDone && masterStatus |=> txDir == !$past(txShift[7]);
  endproperty
  a_master_dir: assert property (p_master_dir)
    else $error("master direction bit not followed");

  property p_start_gen;
    stgPulse && !lostNow && !byteDone |=> txDir && masterStatus;
  endproperty
  a_start_gen: assert property (p_start_gen)
    else $error("start generation did not set direction");

  property p_slave_dir;
    byteDone && !masterStatus |=> txDir == $past(line.sdaLvl);
  endproperty
  a_slave_dir: assert property (p_slave_dir)
    else $error("slave direction bit not followed");

  property p_wrel;
    s_wrel_req |=> !txDir && sdaOeN;
  endproperty
  a_wrel: assert property (p_wrel)
    else $error("wait release kept transmit status");

  property p_ctrl_en;
    wrCtrl |=> unitEn == $past(pwdata[CTRL_EN_BIT]);
  endproperty
  a_ctrl_en: assert property (p_ctrl_en)
    else $error("enable bit not stored");

  property p_arb_lost;
    lostNow && !byteDone |=> arbLost && !masterStatus && !txDir;
  endproperty
  a_arb_lost: assert property (p_arb_lost)
    else $error("arbitration loss not handled");

  property p_match_ro;
    $rose(addrMatch) |-> $past(setMatch);
  endproperty
  a_match_ro: assert property (p_match_ro)
    else $error("address match set without cause");

endmodule // iads_status_top

// *** test/i2c_address_direction_status_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errorCnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module i2c_address_direction_status_test;
  import iads_pkg::*;

  localparam logic [31:0] EN   = 32'h0000_0080;
  localparam logic [31:0] EXIT = 32'h0000_0040;
  localparam logic [31:0] WREL = 32'h0000_0020;
  localparam logic [31:0] STG  = 32'h0000_0002;
  localparam logic [32:0] FULL = 33'h1_ffff_ffff;
  localparam logic [32:0] MD   = 33'h1_0000_0018;

  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sdaOut;
  logic        sdaOeN;
  logic        irq;
  logic        scl;
  logic        sdaLow;
  logic        sdaWire;
  logic [32:0] expQ[$];
  logic [32:0] mskQ[$];
  logic [32:0] e;
  logic [32:0] m;
  logic [7:0]  la;
  logic [7:0]  sh;
  int          errorCnt = 0;
  int          checks   = 0;
  int          seed     = 13;

  always #12.5 clk_sys = ~clk_sys;

  // wired-and line with pull-up
  assign sdaWire = !sdaLow && (sdaOeN || sdaOut);

  iads_status_top dut (
    .clk_sys (clk_sys),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .sclIn   (scl),
    .sdaIn   (sdaWire),
    .sdaOut  (sdaOut),
    .sdaOeN  (sdaOeN),
    .irq     (irq)
  );

  iads_bus_model bus (
    .scl    (scl),
    .sdaLow (sdaLow)
  );

  // ----------------------------------------------------------------
  // apb master and read monitor
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] ex, input logic [32:0] mk);
    expQ.push_back(ex);
    mskQ.push_back(mk);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic [32:0] stw(input logic mt, input logic dr);
    return {28'b0, mt, dr, 3'b000};
  endfunction

  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      `CHK({pslverr, prdata} & m, e & m)
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #500_000;
    errorCnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_CTRL, 33'h0_0000_0000, FULL);
    rd(OFF_STATUS, 33'h0_0000_0000, FULL);
    rd(OFF_LADDR, {25'b0, LADDR_RST}, FULL);
    rd(OFF_SHIFT, {25'b0, SHIFT_RST}, FULL);
    rd(OFF_INT_EN, {29'b0, INT_EN_RST}, FULL);
    rd(8'hfc, 33'h1_0000_0000, FULL);
    wr(OFF_STATUS, 32'hffff_ffff);
    rd(OFF_STATUS, 33'h0_0000_0000, FULL);
    wr(OFF_CTRL, EN);
    // addressed slave, read direction, wait release
    la = 8'($random(seed));
    sh = 8'($random(seed));
    wr(OFF_LADDR, {24'b0, la});
    wr(OFF_SHIFT, {24'b0, sh});
    wr(OFF_INT_EN, 32'h0000_0000);
    bus.start();
    bus.bits8(la | 8'h01);
    idle(4);
    rd(OFF_STATUS, stw(1'b1, 1'b1), MD);
    wr(OFF_STATUS, 32'h0000_0000);
    rd(OFF_STATUS, stw(1'b1, 1'b1), MD);
    `CHK(sdaOeN, 1'b1)
    bus.ninth();
    idle(4);
    `CHK({sdaOeN, sdaOut}, {1'b0, sh[7]})
    rd(OFF_INT_STAT, 33'(1) << INT_START_BIT, 33'(1) << INT_START_BIT);
    `CHK(irq, 1'b0)
    wr(OFF_INT_EN, 32'(1) << INT_START_BIT);
    idle(2);
    `CHK(irq, 1'b1)
    wr(OFF_INT_CLR, 32'h0000_000f);
    idle(2);
    `CHK(irq, 1'b0)
    wr(OFF_CTRL, EN | WREL);
    idle(2);
    `CHK(sdaOeN, 1'b1)
    rd(OFF_STATUS, stw(1'b1, 1'b0), MD);
    bus.stop();
    idle(4);
    rd(OFF_STATUS, stw(1'b0, 1'b0), MD);
    // write direction: cleared by exit, by disable, and a mismatch
    for (int k = 0; k < 3; k++) begin
      la = 8'($random(seed));
      wr(OFF_LADDR, {24'b0, la});
      bus.start();
      bus.bits8((k == 2) ? ((la ^ 8'h02) & 8'hfe) : (la & 8'hfe));
      bus.ninth();
      idle(4);
      rd(OFF_STATUS, stw(k != 2, 1'b0), MD);
      `CHK(sdaOeN, 1'b1)
      if (k == 0) wr(OFF_CTRL, EN | EXIT);
      if (k == 1) wr(OFF_CTRL, 32'h0000_0000);
      idle(2);
      rd(OFF_STATUS, stw(1'b0, 1'b0), MD);
      bus.stop();
      if (k == 1) wr(OFF_CTRL, EN);
      idle(4);
    end
    // master: direction is the inverse of the lsb sent
    for (int k = 0; k < 2; k++) begin
      sh = (k == 0) ? 8'ha5 : 8'ha4;
      wr(OFF_SHIFT, {24'b0, sh});
      wr(OFF_CTRL, EN | STG);
      idle(2);
      rd(OFF_STATUS, 33'h0_0000_0088, 33'h1_0000_0088);
      bus.start();
      bus.bits8(8'hff);
      idle(4);
      rd(OFF_STATUS, {29'b0, 1'(k), 3'b000}, MD);
      wr(OFF_CTRL, EN | EXIT);
      idle(2);
      rd(OFF_STATUS, 33'h0_0000_0000, 33'h1_0000_0088);
      bus.stop();
      idle(4);
    end
    // master loses arbitration on the first bit
    wr(OFF_SHIFT, 32'h0000_00ff);
    wr(OFF_INT_EN, 32'(1) << INT_ARB_BIT);
    wr(OFF_CTRL, EN | STG);
    idle(2);
    bus.bits8(8'h00);
    idle(4);
    `CHK(irq, 1'b1)
    rd(OFF_STATUS, 33'h0_0000_0040, 33'h1_0000_00c8);
    rd(OFF_STATUS, 33'h0_0000_0000, 33'h1_0000_0040);
    wr(OFF_INT_CLR, 32'h0000_000f);
    idle(2);
    `CHK(irq, 1'b0)
    bus.stop();
    idle(4);
    print_verdict();
  end

endmodule // i2c_address_direction_status_test

// *** test/iads_bus_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side of the two-wire bus: open-drain driver, clock idles high
// ----------------------------------------------------------------
module iads_bus_model (
  output logic scl,
  output logic sdaLow
);

  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // one clock pulse of a 200 ns period, data changed mid-low
  task automatic pulse();
    #50;
    scl = 1'b1;
    #100;
    scl = 1'b0;
    #50;
  endtask

  // data falls while the clock is high, then the clock falls
  task automatic start();
    sdaLow = 1'b1;
    #100;
    scl = 1'b0;
    #50;
  endtask

  // eight bits msb first; a one is sent by releasing the line
  task automatic bits8(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      sdaLow = !d[i];
      pulse();
    end
  endtask

  // ack slot with the line released
  task automatic ninth();
    sdaLow = 1'b0;
    pulse();
  endtask

  // data rises while the clock is high
  task automatic stop();
    sdaLow = 1'b1;
    #50;
    scl = 1'b1;
    #100;
    sdaLow = 1'b0;
    #100;
  endtask

endmodule // iads_bus_model
